// file: eita_top.sv
/*
  trip action decision logic with an apb register slave and a sticky alert register.
  assumes controller phase, main-fuel and slot inputs arrive synchronous to pclk
  except the digital airflow pin, which is synchronised here.
*/
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module eita_top #(
  parameter int SLOTS = eita_pkg::SLOTS,
  parameter int LVL_W = eita_pkg::LVL_W
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic                              pready,
  output logic [31:0]                       prdata,
  output logic                              pslverr,
  input  wire logic [1:0]                   phase,
  input  wire logic                         main_fuel,
  input  wire logic                         fuel_state,
  input  wire logic [SLOTS-1:0]             slot_comm,
  input  wire logic [SLOTS-1:0]             slot_out_of_range,
  input  wire logic [SLOTS*LVL_W-1:0]       slot_level,
  input  wire logic                         airflow_proof_input,
  output logic [2:0]                        go_request,
  output logic                              go_valid,
  output logic [eita_pkg::ALERT_W-1:0]      alert_now,
  output logic                              irq
);
  localparam int AW = eita_pkg::ALERT_W;

  typedef struct packed {
    eita_pkg::eita_cfg_t cfg;
    logic [LVL_W-1:0]    low_trip;
    logic [LVL_W-1:0]    high_trip;
    logic [AW-1:0]       status;
    logic [AW-1:0]       mask;
    logic                owner_valid;
    logic [1:0]          owner;
    logic [1:0]          af_sync;
    eita_pkg::eita_act_t act;
    logic [31:0]         rdata;
  } eita_state_t;

  eita_state_t s_q, s_d;

  // ---------------------------------------------------------------
  // level evaluation of the owning slot
  // ---------------------------------------------------------------
  logic [SLOTS-1:0] first_hot;
  logic [1:0]       first_idx;
  logic [LVL_W-1:0] lvl;
  logic             range_bad;
  eita_pkg::eita_lvl_t lvl_st;
  logic             proven;
  logic             lo_t;
  logic             hi_t;

  // only a communicating slot can become owner; lowest index breaks a tie
  always_comb begin
    first_idx = 2'h0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (slot_comm[i]) begin
        first_idx = 2'(i);
      end
    end
  end
  assign first_hot = slot_comm;

  always_comb begin
    lvl       = slot_level[s_q.owner*LVL_W +: LVL_W];
    range_bad = slot_out_of_range[s_q.owner] || !s_q.owner_valid;
    if (range_bad) begin
      lvl_st = eita_pkg::LVL_RANGE;
    end else if (lvl <= s_q.low_trip) begin
      lvl_st = eita_pkg::LVL_LOW;
    end else if (lvl >= s_q.high_trip) begin
      lvl_st = eita_pkg::LVL_HIGH;
    end else begin
      lvl_st = eita_pkg::LVL_OK;
    end
    proven = s_q.cfg.digital ? s_q.af_sync[1] : (lvl_st == eita_pkg::LVL_OK);
    lo_t   = (lvl_st == eita_pkg::LVL_LOW);
    hi_t   = (lvl_st == eita_pkg::LVL_HIGH);
  end

  // ---------------------------------------------------------------
  // decision table
  // ---------------------------------------------------------------
  eita_pkg::eita_act_t act;
  logic stopped;
  logic trip;

  always_comb begin
    act     = '0;
    act.go  = eita_pkg::GO_NONE;
    stopped = (phase == eita_pkg::ST_STOPPED) || (phase == eita_pkg::ST_CHECKS);
    trip    = lo_t || hi_t;
    if (s_q.cfg.mode == eita_pkg::MODE_AIRFLOW) begin
      if (!s_q.cfg.digital && (lvl_st == eita_pkg::LVL_RANGE || hi_t)) begin
        act.go = stopped ? eita_pkg::GO_ALARM : eita_pkg::GO_LOCKOUT;
        act.alerts[eita_pkg::AL_AF_INV] = 1'b1;
      end else if (phase == eita_pkg::ST_CHECKS) begin
        act.go = proven ? eita_pkg::GO_LOCKOUT : eita_pkg::GO_PREPURGE;
        act.alerts[eita_pkg::AL_AF_STCK] = proven;
      end else if (phase == eita_pkg::ST_PREPURGE && !proven) begin
        act.go = eita_pkg::GO_LOCKOUT;
        act.alerts[eita_pkg::AL_AF_PURG] = 1'b1;
      end else if (fuel_state && s_q.cfg.forced_draft && !proven) begin
        act.go = eita_pkg::GO_LOCKOUT;
        act.alerts[eita_pkg::AL_AF_RUN] = 1'b1;
      end
      // purge fan in a fuel state falls through with no effect
    end else if (s_q.cfg.mode == eita_pkg::MODE_DISPLAY) begin
      act.go = eita_pkg::GO_NONE;
    end else if (lvl_st == eita_pkg::LVL_RANGE) begin
      if (s_q.cfg.mode != eita_pkg::MODE_WARN) begin
        act.go = stopped ? eita_pkg::GO_ALARM : eita_pkg::GO_LOCKOUT;
        act.alerts[eita_pkg::AL_INVALID] = 1'b1;
      end
    end else if (trip) begin
      unique case (s_q.cfg.mode)
        eita_pkg::MODE_ALARM: begin
          act.go = stopped ? eita_pkg::GO_ALARM : eita_pkg::GO_LOCKOUT;
          act.alerts[eita_pkg::AL_AN_LOW]  = lo_t;
          act.alerts[eita_pkg::AL_AN_HIGH] = hi_t;
        end
        eita_pkg::MODE_WAIT: begin
          act.go = stopped ? eita_pkg::GO_NONE : eita_pkg::GO_WAITING;
          act.alerts[eita_pkg::AL_W_LOW]  = lo_t;
          act.alerts[eita_pkg::AL_W_HIGH] = hi_t;
        end
        eita_pkg::MODE_WARN: begin
          act.alerts[eita_pkg::AL_WN_LOW]  = lo_t;
          act.alerts[eita_pkg::AL_WN_HIGH] = hi_t;
        end
        eita_pkg::MODE_MAIN: begin
          if (main_fuel) begin
            act.go = s_q.cfg.pilot_off_after_main ? eita_pkg::GO_WAITING
                                                  : eita_pkg::GO_PILOT;
          end
          act.alerts[eita_pkg::AL_MP_LOW]  = lo_t;
          act.alerts[eita_pkg::AL_MP_HIGH] = hi_t;
        end
        default: act.go = eita_pkg::GO_NONE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers and apb slave
  // ---------------------------------------------------------------
  logic wr;
  logic rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  always_comb begin
    s_d         = s_q;
    s_d.af_sync = {s_q.af_sync[0], airflow_proof_input};
    s_d.act     = act;
    // ownership latches on the first slot to talk and never moves
    if (!s_q.owner_valid && |first_hot) begin
      s_d.owner_valid = 1'b1;
      s_d.owner       = first_idx;
    end
    if (wr) begin
      unique case (paddr)
        eita_pkg::ADDR_CFG: s_d.cfg = eita_pkg::eita_cfg_t'(pwdata[5:0]);
        eita_pkg::ADDR_TRIPS: begin
          s_d.low_trip  = pwdata[LVL_W-1:0];
          s_d.high_trip = pwdata[2*LVL_W-1:LVL_W];
        end
        eita_pkg::ADDR_STATUS: s_d.status = s_q.status & ~pwdata[AW-1:0];
        eita_pkg::ADDR_MASK:   s_d.mask = pwdata[AW-1:0];
        default: ;
      endcase
    end
    // new alerts win over a same-cycle clear
    s_d.status = s_d.status | act.alerts;
    if (rd) begin
      unique case (paddr)
        eita_pkg::ADDR_CFG:    s_d.rdata = 32'(s_q.cfg);
        eita_pkg::ADDR_LOOP:   s_d.rdata = 32'({s_q.owner_valid, s_q.owner, lvl_st, lvl});
        eita_pkg::ADDR_TRIPS:  s_d.rdata = {s_q.high_trip, s_q.low_trip};
        eita_pkg::ADDR_STATUS: s_d.rdata = 32'(s_q.status);
        eita_pkg::ADDR_MASK:   s_d.rdata = 32'(s_q.mask);
        eita_pkg::ADDR_ACTION: s_d.rdata = 32'(s_q.act);
        default:               s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready     = 1'b1;
  assign pslverr    = 1'b0;
  assign prdata     = s_q.rdata;
  assign go_request = s_q.act.go;
  assign go_valid   = (s_q.act.go != eita_pkg::GO_NONE);
  assign alert_now  = s_q.act.alerts;
  assign irq        = |(s_q.status & s_q.mask);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_range_invalid: assert property (@(posedge pclk) disable iff (!presetn)
    (lvl_st == eita_pkg::LVL_RANGE && s_q.cfg.mode == eita_pkg::MODE_ALARM)
    |=> alert_now[eita_pkg::AL_INVALID] && go_valid)
    else $error("out of range not invalid");
  a_alarm_stopped: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.cfg.mode == eita_pkg::MODE_ALARM && trip && phase == eita_pkg::ST_STOPPED
     && lvl_st != eita_pkg::LVL_RANGE) |=> go_request == eita_pkg::GO_ALARM)
    else $error("alarm mode stopped wrong");
  a_alarm_running: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.cfg.mode == eita_pkg::MODE_ALARM && hi_t && phase == eita_pkg::ST_RUNNING)
    |=> go_request == eita_pkg::GO_LOCKOUT && alert_now[eita_pkg::AL_AN_HIGH])
    else $error("alarm mode running wrong");
  a_wait_running: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.cfg.mode == eita_pkg::MODE_WAIT && lo_t && phase == eita_pkg::ST_RUNNING)
    |=> go_request == eita_pkg::GO_WAITING && alert_now[eita_pkg::AL_W_LOW])
    else $error("wait mode running wrong");
  a_warn_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.cfg.mode == eita_pkg::MODE_WARN) |=> !go_valid)
    else $error("warning mode moved state");
  a_main_pilot: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.cfg.mode == eita_pkg::MODE_MAIN && trip && main_fuel
     && !s_q.cfg.pilot_off_after_main) |=> go_request == eita_pkg::GO_PILOT)
    else $error("main permissive not pilot");
  a_owner_stable: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.owner_valid |=> s_q.owner_valid && $stable(s_q.owner))
    else $error("slot owner changed");
  a_display_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.cfg.mode == eita_pkg::MODE_DISPLAY) |=> !go_valid && alert_now == '0)
    else $error("display only acted");
endmodule

// file: eita_pkg.sv
/*
  package for the expansion input trip action block: apb map, encodings, carriers.
  assumes a 32-bit apb master on pclk.
*/
// Function
// - out-of-range loop input raises invalid alarm, except in warning, display and digital airflow modes
// - alarm mode stopped: trip gives alarm state
// - alarm mode running: trip gives lockout
// - wait mode stopped: alert only, no transition
// - wait mode running: trip gives waiting
// - warning mode: alert only, never transition
// - main-permissive non-main: alert only
// - main-permissive main fuel: drop to pilot
// - pilot-off-after-main: permissive trip gives waiting
// - redundant slots follow first communicating slot
// - proven pre-purge: unproven airflow gives lockout
// - forced draft fuel state: unproven airflow lockout
// - loop airflow range/high fault: invalid alarm
// - valid range strictly between trip settings
package eita_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_LOOP   = 8'h04;
  localparam logic [7:0] ADDR_TRIPS  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  localparam logic [7:0] ADDR_ACTION = 8'h14;
  localparam int ALERT_W = 12;
  localparam int LVL_W   = 16;
  localparam int SLOTS   = 4;

  typedef enum logic [2:0] {
    MODE_ALARM, MODE_WAIT, MODE_WARN, MODE_MAIN, MODE_DISPLAY, MODE_AIRFLOW
  } eita_mode_t;
  typedef enum logic [1:0] {ST_STOPPED, ST_RUNNING, ST_CHECKS, ST_PREPURGE} eita_phase_t;
  typedef enum logic [2:0] {
    GO_NONE, GO_ALARM, GO_LOCKOUT, GO_WAITING, GO_PILOT, GO_PREPURGE
  } eita_go_t;
  typedef enum logic [1:0] {LVL_OK, LVL_LOW, LVL_HIGH, LVL_RANGE} eita_lvl_t;

  // alert bit positions
  localparam int AL_INVALID = 0;
  localparam int AL_AN_LOW  = 1;
  localparam int AL_AN_HIGH = 2;
  localparam int AL_W_LOW   = 3;
  localparam int AL_W_HIGH  = 4;
  localparam int AL_WN_LOW  = 5;
  localparam int AL_WN_HIGH = 6;
  localparam int AL_MP_LOW  = 7;
  localparam int AL_MP_HIGH = 8;
  localparam int AL_AF_PURG = 9;
  localparam int AL_AF_RUN  = 10;
  localparam int AL_AF_STCK = 11;
  localparam int AL_AF_INV  = AL_INVALID;

  typedef struct packed {
    eita_mode_t  mode;
    logic        digital;
    logic        forced_draft;
    logic        pilot_off_after_main;
  } eita_cfg_t;

  typedef struct packed {
    eita_go_t            go;
    logic [ALERT_W-1:0]  alerts;
  } eita_act_t;
endpackage

// file: eita_field_model.sv
/*
  field side model: transmitters on the expansion card slots and the airflow pin.
  assumes the bench steers it on pclk rising edges.
*/
`timescale 1ns/1ps
module eita_field_model #(
  parameter int SLOTS = 4,
  parameter int LVL_W = 16
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [1:0]         own_idx,
  input  wire logic [SLOTS-1:0]   comm_en,
  input  wire logic [LVL_W-1:0]   lvl_set,
  input  wire logic               oor_set,
  input  wire logic               pin_set,
  output logic [SLOTS-1:0]        slot_comm,
  output logic [SLOTS-1:0]        slot_out_of_range,
  output logic [SLOTS*LVL_W-1:0]  slot_level,
  output logic                    airflow_proof_input
);
  // ---------------------------------------------------------------
  // slots
  // ---------------------------------------------------------------
  logic [LVL_W-1:0] junk_q;
  // idle or non-owner slots swing between both trips, never a kind value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) junk_q <= '0;
    else junk_q <= ~junk_q;
  end
  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      slot_comm[i]                 = comm_en[i];
      slot_out_of_range[i]         = (i == own_idx) ? oor_set : 1'b1;
      slot_level[i*LVL_W +: LVL_W] = (i == own_idx && comm_en[i]) ? lvl_set : junk_q;
    end
  end
  assign airflow_proof_input = pin_set;
endmodule

// file: test_expansion_input_trip_actions.sv
/*
  self-checking bench of the trip action block: apb tasks, expectation function, scenarios.
  assumes eita_pkg, eita_top and eita_field_model are compiled first.
*/
`timescale 1ns/1ps
module test_expansion_input_trip_actions;
  localparam logic [15:0] LO_T = 16'h1000;
  localparam logic [15:0] HI_T = 16'hC000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        main_fuel, fuel_state, go_valid, irq, oor_set, pin_set, afp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, lfsr_q;
  logic [1:0]  phase, own_idx;
  logic [3:0]  comm_en, s_comm, s_oor;
  logic [63:0] s_lvl;
  logic [15:0] lvl_set;
  logic [2:0]  go_request;
  logic [11:0] alert_now;
  int          err_total, n_checks;
  eita_pkg::eita_act_t e;

  eita_field_model FM (.pclk(pclk), .presetn(presetn), .own_idx(own_idx), .comm_en(comm_en),
    .lvl_set(lvl_set), .oor_set(oor_set), .pin_set(pin_set), .slot_comm(s_comm),
    .slot_out_of_range(s_oor), .slot_level(s_lvl), .airflow_proof_input(afp));
  eita_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .phase(phase), .main_fuel(main_fuel), .fuel_state(fuel_state),
    .slot_comm(s_comm), .slot_out_of_range(s_oor), .slot_level(s_lvl),
    .airflow_proof_input(afp), .go_request(go_request), .go_valid(go_valid),
    .alert_now(alert_now), .irq(irq));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (ex !== got) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, ex, got);
    end
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // pready is sampled only at rising edges; the bound stands in for a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    rd = prdata;
    psel <= 0; penable <= 0;
  endtask
  function automatic eita_pkg::eita_act_t expect_act(input logic [2:0] md, input logic [1:0] ph,
      input logic mf, fs, pom, dig, fd, input logic [15:0] lv, input logic oor, pin);
    logic [2:0] g; logic [11:0] al; logic stp, hi, lo, pr; int b;
    g = 0; al = 0; stp = !ph[0]; hi = lv >= HI_T; lo = lv <= LO_T; b = hi ? 1 : 0;
    pr = dig ? pin : !(oor | hi | lo);
    if (md == 3'd5) begin
      if (!dig && (oor || hi)) begin g = stp ? 1 : 2; al[0] = 1; end
      else if (ph == 2) begin g = pr ? 2 : 5; al[11] = pr; end
      else if (ph == 3) begin g = pr ? 0 : 2; al[9] = !pr; end
      else if (fs && fd && !pr) begin g = 2; al[10] = 1; end
    end else if (md == 3'd4 || (md == 3'd2 && oor)) g = 0;
    else if (oor) begin g = stp ? 1 : 2; al[0] = 1; end
    else if (hi || lo) begin
      case (md)
        3'd0: begin g = stp ? 1 : 2; al[1+b] = 1; end
        3'd1: begin g = stp ? 0 : 3; al[3+b] = 1; end
        3'd2: al[5+b] = 1;
        default: begin g = mf ? (pom ? 3 : 4) : 0; al[7+b] = 1; end
      endcase
    end
    return {g, al};
  endfunction
  task automatic run_case(input logic [2:0] md, input logic [1:0] ph, input logic mf, fs, pom,
      dig, fd, input logic [1:0] ls, input logic pin);
    logic [15:0] lv;
    lfsr_q = lfsr_next(lfsr_q);
    // trip values at or past the trip, valid values one step inside
    lv = ls == 1 ? LO_T - lfsr_q[1:0] : ls == 2 ? HI_T + lfsr_q[1:0] : lfsr_q[2] ? LO_T + 1 : HI_T - 1;
    apb(1, eita_pkg::ADDR_CFG, {26'h0, md, dig, fd, pom});
    phase <= ph; main_fuel <= mf; fuel_state <= fs; lvl_set <= lv; oor_set <= ls == 3;
    pin_set <= pin;
    // covers the two-flop pin synchroniser plus the registered decision
    repeat (4) @(posedge pclk);
    e = expect_act(md, ph, mf, fs, pom, dig, fd, lv, ls == 3, pin);
    chk("alerts", e.alerts, alert_now);
    chk("go", e.go, go_request);
    chk("go_valid", e.go != 0, go_valid);
    apb(0, eita_pkg::ADDR_ACTION, 0);
    chk("action", {17'h0, e}, rd);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, main_fuel, fuel_state, oor_set, pin_set} = '0;
    paddr = 0; pwdata = 0; phase = 0; own_idx = 2; comm_en = 0; lvl_set = LO_T + 1;
    lfsr_q = 32'h50a8; err_total = 0; n_checks = 0; presetn = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(1, eita_pkg::ADDR_TRIPS, {HI_T, LO_T});
    apb(1, eita_pkg::ADDR_CFG, 0);
    repeat (4) @(posedge pclk);
    chk("no_comm_go", 1, go_request);
    comm_en <= 4'h4;
    repeat (3) @(posedge pclk);
    comm_en <= 4'hF;
    run_case(0, 0, 0, 0, 0, 0, 0, 0, 0);
    apb(0, eita_pkg::ADDR_LOOP, 0);
    chk("owner", 32'h6, rd[20:18]);
    comm_en <= 4'h4;
    run_case(0, 1, 0, 0, 0, 0, 0, 1, 0);
    comm_en <= 4'hF;
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 96; c++) begin
        run_case(c / 16, c[3:2], c[3:2] == 1 && p[0], c[3:2] == 1 && (p[0] | lfsr_q[6]), p[1],
          c / 16 == 5 && lfsr_q[8], lfsr_q[9], c[1:0], lfsr_q[10]);
      end
    end
    run_case(4, 0, 0, 0, 0, 0, 0, 1, 0);
    apb(1, eita_pkg::ADDR_STATUS, 32'hFFF);
    apb(0, eita_pkg::ADDR_STATUS, 0);
    chk("status_clr", 0, rd);
    run_case(2, 1, 0, 0, 0, 0, 0, 1, 0);
    run_case(4, 1, 0, 0, 0, 0, 0, 2, 0);
    apb(0, eita_pkg::ADDR_STATUS, 0);
    chk("status_sticky", 32'h20, rd);
    chk("irq_masked", 0, irq);
    apb(1, eita_pkg::ADDR_MASK, 32'h20);
    repeat (2) @(posedge pclk);
    chk("irq_on", 1, irq);
    apb(1, eita_pkg::ADDR_STATUS, 32'h20);
    apb(0, 8'h1C, 0);
    chk("unmapped", 0, rd);
    chk("unmapped_err", 0, pslverr);
    chk("irq_off", 0, irq);
    tally_and_finish();
  end
endmodule
